// ### src/sbs_sram.sv
`timescale 1ns/1ps
`include "sbs_params.svh"
module sbs_sram import sbs_pkg::*; #(
  parameter int AW = `SBS_AW,
  parameter int LANES = `SBS_LANES,
  parameter int LW = `SBS_LANE_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Synchronous controls
  input wire logic [AW-1:0] addr_in,
  input wire logic chip_sel0_n_in,
  input wire logic chip_sel1_in,
  input wire logic chip_sel2_n_in,
  input wire logic we_n_in,
  input wire logic [LANES-1:0] byte_we_n_in,
  input wire logic burst_advance_in,
  input wire logic clk_en_n_in,
  // Static and asynchronous controls
  input wire logic flowthru_sel_n_in,
  input wire logic burst_order_sel_n_in,
  input wire logic parity_odd_sel_in,
  input wire logic out_en_n_in,
  input wire logic sleep_req_in,
  // Data bus
  input wire logic [LANES*LW-1:0] dq_in,
  output logic [LANES*LW-1:0] dq_out,
  output logic dq_oe_out,
  // Status
  output logic wr_parity_err_out,
  output logic rd_parity_err_out,
  output logic sleep_out,
  // Test access port
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out
);
  typedef struct packed {
    logic v;
    logic we;
    logic [AW-1:0] a;
    logic [LANES-1:0] bw;
  } sbs_cmd_s;

  typedef struct packed {
    sbs_cmd_s c1;
    sbs_cmd_s c2;
    logic [1:0] start;
    logic [1:0] step;
    logic [LANES*LW-1:0] dout;
    logic dvld;
    logic rperr;
    logic wperr;
  } sbs_state_s;

  logic [LANES*LW-1:0] mem [2**AW];
  sbs_state_s q, d;
  sbs_cmd_s wc;
  logic pipe, sel, go, drive;
  logic [LANES*LW-1:0] rd_word, fwd_word;
  logic [1:0] nstep;

  function automatic logic [LANES-1:0] lane_perr(input logic [LANES*LW-1:0] w, input logic odd);
    for (int i = 0; i < LANES; i++) begin
      lane_perr[i] = (^w[i*LW +: LW]) ^ odd;
    end
  endfunction

  function automatic logic [1:0] burst_lo(input logic [1:0] s, input logic [1:0] k, input logic il);
    burst_lo = il ? (s ^ k) : 2'(s + k);
  endfunction

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  assign pipe = flowthru_sel_n_in;
  assign sel = ~chip_sel0_n_in & chip_sel1_in & ~chip_sel2_n_in;
  assign go = ~clk_en_n_in & ~sleep_req_in;
  assign sleep_out = sleep_req_in;
  assign wc = pipe ? q.c2 : q.c1;
  assign nstep = 2'(q.step + 2'h1);
  assign rd_word = mem[q.c1.a];

  always_comb begin
    fwd_word = rd_word;
    if (wc.v && wc.we && wc.a == q.c1.a) begin
      for (int i = 0; i < LANES; i++) begin
        if (wc.bw[i]) begin
          fwd_word[i*LW +: LW] = dq_in[i*LW +: LW];
        end
      end
    end
  end

  // ----------------------------------------
  // Pipeline state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.wperr = 1'b0;
    if (go) begin
      d.c2 = q.c1;
      d.c1.bw = ~byte_we_n_in;
      if (burst_advance_in) begin
        d.step = nstep;
        d.c1.a = {q.c1.a[AW-1:2], burst_lo(q.start, nstep, burst_order_sel_n_in)};
      end else begin
        d.c1.v = sel;
        d.c1.we = ~we_n_in;
        d.c1.a = addr_in;
        d.start = addr_in[1:0];
        d.step = 2'h0;
      end
      d.dvld = q.c1.v & ~q.c1.we;
      d.dout = fwd_word;
      d.rperr = q.c1.v & ~q.c1.we & (|lane_perr(fwd_word, parity_odd_sel_in));
      d.wperr = wc.v & wc.we & (|(wc.bw & lane_perr(dq_in, parity_odd_sel_in)));
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Array write
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (go && wc.v && wc.we) begin
      for (int i = 0; i < LANES; i++) begin
        if (wc.bw[i]) begin
          mem[wc.a][i*LW +: LW] <= dq_in[i*LW +: LW];
        end
      end
    end
  end

  // ----------------------------------------
  // Output drivers
  // ----------------------------------------
  assign drive = pipe ? q.dvld : (q.c1.v & ~q.c1.we);
  assign dq_out = pipe ? q.dout : rd_word;
  assign dq_oe_out = drive & ~out_en_n_in & ~sleep_req_in;
  assign rd_parity_err_out = pipe ? (q.dvld & q.rperr) :
                             (drive & (|lane_perr(rd_word, parity_odd_sel_in)));
  assign wr_parity_err_out = q.wperr;

  sbs_tap u_tap (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .tck_in(tck_in),
    .tms_in(tms_in),
    .tdi_in(tdi_in),
    .tdo_out(tdo_out),
    .tdo_oe_out(tdo_oe_out),
    .sample_in(`SBS_DR_W'({addr_in[AW-1:0], chip_sel0_n_in, chip_sel1_in, chip_sel2_n_in, we_n_in,
                burst_advance_in, clk_en_n_in, out_en_n_in, sleep_req_in, byte_we_n_in, dq_in[0]}))
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence rd_acc;
    go && sel && we_n_in && !burst_advance_in;
  endsequence
  sequence wr_acc;
    go && sel && !we_n_in && !burst_advance_in;
  endsequence

  a_oe_async_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    out_en_n_in |-> !dq_oe_out)
    else $error("Drivers on while output enable off");
  a_sleep_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    sleep_req_in |-> (sleep_out && !dq_oe_out))
    else $error("Drivers on during sleep");
  a_pipe_rd_lat: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (rd_acc and pipe) ##1 (go && pipe) |=> (q.dvld && (dq_oe_out || out_en_n_in || sleep_req_in)))
    else $error("Pipelined read not driven after two edges");
  a_flow_rd_drive: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (rd_acc and !pipe) ##1 !pipe |-> (dq_oe_out || out_en_n_in || sleep_req_in))
    else $error("Flow read not driven in next cycle");
  a_wr_no_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    rd_acc ##1 wr_acc |=> (q.c1.v && q.c1.we && q.c2.v && !q.c2.we))
    else $error("Write after read not accepted");
  a_clk_en_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    clk_en_n_in |=> ($stable(q.c1) && $stable(q.c2) && $stable(q.dout)))
    else $error("State moved with clock enable high");
  a_deselect_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (go && !sel && !burst_advance_in) |=> !q.c1.v)
    else $error("Deselected cycle accepted");
  a_burst_linear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (go && !burst_advance_in) ##1 (go && burst_advance_in && !burst_order_sel_n_in)[*2]
      |=> q.c1.a[1:0] == 2'($past(addr_in[1:0], 3) + 2'h2))
    else $error("Linear burst address wrong");
endmodule

// ### src/sbs_params.svh
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH
`define SBS_LANE_W 9
`define SBS_LANES 4
`define SBS_AW 19
`define SBS_WR_LAT_PIPE 2
`define SBS_WR_LAT_FLOW 1
`define SBS_IR_W 3
`define SBS_IR_IDCODE 3'h1
`define SBS_IR_SAMPLE 3'h2
`define SBS_IR_BYPASS 3'h7
`define SBS_IR_CAPTURE 3'h1
`define SBS_DR_W 32
`endif

// ### src/sbs_pkg.sv
`include "sbs_params.svh"
package sbs_pkg;
  typedef enum logic [15:0] {
    SBS_TLR = 16'h0001,
    SBS_RTI = 16'h0002,
    SBS_SDR = 16'h0004,
    SBS_CDR = 16'h0008,
    SBS_SHDR = 16'h0010,
    SBS_E1DR = 16'h0020,
    SBS_PDR = 16'h0040,
    SBS_E2DR = 16'h0080,
    SBS_UDR = 16'h0100,
    SBS_SIR = 16'h0200,
    SBS_CIR = 16'h0400,
    SBS_SHIR = 16'h0800,
    SBS_E1IR = 16'h1000,
    SBS_PIR = 16'h2000,
    SBS_E2IR = 16'h4000,
    SBS_UIR = 16'h8000
  } sbs_tap_e;
endpackage

// ### src/sbs_tap.sv
`timescale 1ns/1ps
`include "sbs_params.svh"
module sbs_tap import sbs_pkg::*; #(
  parameter logic [`SBS_DR_W-1:0] ID_CODE = 32'h0000_1001 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Test port pins
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  // Pin states for sampling
  input wire logic [`SBS_DR_W-1:0] sample_in
);
  typedef struct packed {
    logic tck;
    sbs_tap_e st;
    logic [`SBS_IR_W-1:0] ir;
    logic [`SBS_IR_W-1:0] ir_sh;
    logic [`SBS_DR_W-1:0] sh;
    logic tdo;
    logic tdo_oe;
  } sbs_tap_s;

  sbs_tap_s q, d;
  logic rise, fall;

  function automatic sbs_tap_e next_st(input sbs_tap_e s, input logic m);
    unique case (s)
      SBS_TLR: next_st = m ? SBS_TLR : SBS_RTI;
      SBS_RTI: next_st = m ? SBS_SDR : SBS_RTI;
      SBS_SDR: next_st = m ? SBS_SIR : SBS_CDR;
      SBS_CDR: next_st = m ? SBS_E1DR : SBS_SHDR;
      SBS_SHDR: next_st = m ? SBS_E1DR : SBS_SHDR;
      SBS_E1DR: next_st = m ? SBS_UDR : SBS_PDR;
      SBS_PDR: next_st = m ? SBS_E2DR : SBS_PDR;
      SBS_E2DR: next_st = m ? SBS_UDR : SBS_SHDR;
      SBS_UDR: next_st = m ? SBS_SDR : SBS_RTI;
      SBS_SIR: next_st = m ? SBS_TLR : SBS_CIR;
      SBS_CIR: next_st = m ? SBS_E1IR : SBS_SHIR;
      SBS_SHIR: next_st = m ? SBS_E1IR : SBS_SHIR;
      SBS_E1IR: next_st = m ? SBS_UIR : SBS_PIR;
      SBS_PIR: next_st = m ? SBS_E2IR : SBS_PIR;
      SBS_E2IR: next_st = m ? SBS_UIR : SBS_SHIR;
      SBS_UIR: next_st = m ? SBS_SDR : SBS_RTI;
      default: next_st = SBS_TLR;
    endcase
  endfunction

  // ----------------------------------------
  // Test access port state machine
  // ----------------------------------------
  assign rise = tck_in & ~q.tck;
  assign fall = ~tck_in & q.tck;

  always_comb begin
    d = q;
    d.tck = tck_in;
    if (rise) begin
      d.st = next_st(q.st, tms_in);
      unique case (q.st)
        SBS_TLR: d.ir = `SBS_IR_IDCODE;
        SBS_CDR: d.sh = (q.ir == `SBS_IR_IDCODE) ? ID_CODE :
                        (q.ir == `SBS_IR_SAMPLE) ? sample_in : '0;
        SBS_SHDR: d.sh = (q.ir == `SBS_IR_IDCODE || q.ir == `SBS_IR_SAMPLE) ?
                         {tdi_in, q.sh[`SBS_DR_W-1:1]} : {{(`SBS_DR_W-1){1'b0}}, tdi_in};
        SBS_CIR: d.ir_sh = `SBS_IR_CAPTURE;
        SBS_SHIR: d.ir_sh = {tdi_in, q.ir_sh[`SBS_IR_W-1:1]};
        SBS_UIR: d.ir = q.ir_sh;
        default: d.sh = q.sh;
      endcase
    end
    if (fall) begin
      d.tdo_oe = (q.st == SBS_SHDR) || (q.st == SBS_SHIR);
      d.tdo = (q.st == SBS_SHIR) ? q.ir_sh[0] : q.sh[0];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= '{tck: 1'b0, st: SBS_TLR, ir: `SBS_IR_IDCODE, ir_sh: '0, sh: '0, tdo: 1'b0, tdo_oe: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign tdo_out = q.tdo;
  assign tdo_oe_out = q.tdo_oe;

  a_tap_tdo_drive: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (fall && q.st == SBS_SHDR) |=> tdo_oe_out)
    else $error("Test data out not driven in shift");
  a_tap_tlr_ir: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (rise && q.st == SBS_TLR) |=> q.ir == `SBS_IR_IDCODE)
    else $error("Instruction not reset in logic reset");
endmodule

// ### tb/sbs_host_model.sv
`timescale 1ns/1ps
`include "sbs_params.svh"
// ----------------------------------------
// Memory controller model
// ----------------------------------------
module sbs_host_model (
  // Mode
  input wire logic pipe_in,
  // Bus
  output logic [`SBS_AW-1:0] addr_out,
  output logic chip_sel0_n_out,
  output logic chip_sel1_out,
  output logic chip_sel2_n_out,
  output logic we_n_out,
  output logic [3:0] byte_we_n_out,
  output logic burst_advance_out,
  output logic [35:0] dq_out
);
  logic [36:0] q0 = '0;
  logic [36:0] q1 = '0;
  logic [36:0] q2 = '0;
  logic [36:0] nx;
  initial begin
    {chip_sel0_n_out, chip_sel1_out, chip_sel2_n_out} = 3'h5;
    {we_n_out, burst_advance_out, byte_we_n_out} = 6'h2f;
    addr_out = '0;
    dq_out = '0;
  end
  // One call per clock, just after the falling edge
  task automatic op(input logic [2:0] cs, input logic wn, input logic av, input logic [`SBS_AW-1:0] a,
                    input logic [3:0] bw, input logic [35:0] d);
    {chip_sel0_n_out, chip_sel1_out, chip_sel2_n_out} = cs;
    we_n_out = wn;
    burst_advance_out = av;
    addr_out = a;
    byte_we_n_out = bw;
    q2 = q1;
    q1 = q0;
    q0 = {~wn, d};
    nx = pipe_in ? q2 : q1;
    dq_out = nx[36] ? nx[35:0] : ~dq_out;
  endtask
endmodule

// ### tb/sync_burst_sram_no_turnaround_bench.sv
`timescale 1ns/1ps
`include "sbs_params.svh"
module sync_burst_sram_no_turnaround_bench;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] OFF = 3'h5;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic ce_n = 1'b0;
  logic flow_sel_n = 1'b1;
  logic order_sel_n = 1'b0;
  logic tck = 1'b0;
  logic tms = 1'b0;
  logic tdi = 1'b0;
  localparam logic [`SBS_DR_W-1:0] ID_CODE = 32'h0000_1001; // Arbitrary value, as in the test port
  logic odd = 1'b0;
  logic oe_n = 1'b0;
  logic slp = 1'b0;
  logic [18:0] addr;
  logic cs0_n, cs1, cs2_n, we_n, advance, oe_d, wr_err, rd_err, slp_d, tdo, tdo_oe;
  logic [3:0] bw_n;
  logic [35:0] dq_h, dq_d, m0;
  int err_count = 0;
  int n_compared = 0;
  sbs_host_model u_sbs_host_model (.pipe_in(flow_sel_n), .addr_out(addr), .chip_sel0_n_out(cs0_n),
    .chip_sel1_out(cs1), .chip_sel2_n_out(cs2_n), .we_n_out(we_n), .byte_we_n_out(bw_n),
    .burst_advance_out(advance), .dq_out(dq_h));
  sbs_sram u_sbs_sram (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr), .chip_sel0_n_in(cs0_n),
    .chip_sel1_in(cs1), .chip_sel2_n_in(cs2_n), .we_n_in(we_n), .byte_we_n_in(bw_n),
    .burst_advance_in(advance), .clk_en_n_in(ce_n), .flowthru_sel_n_in(flow_sel_n),
    .burst_order_sel_n_in(order_sel_n),
    .parity_odd_sel_in(odd), .out_en_n_in(oe_n), .sleep_req_in(slp), .dq_in(dq_h), .dq_out(dq_d),
    .dq_oe_out(oe_d), .wr_parity_err_out(wr_err), .rd_parity_err_out(rd_err), .sleep_out(slp_d),
    .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [35:0] par(input logic [31:0] x, input logic o);
    logic [35:0] r;
    for (int i = 0; i < 4; i++) r[9*i +: 9] = {^x[8*i +: 8] ^ o, x[8*i +: 8]};
    return r;
  endfunction
  function automatic logic [35:0] wd(input int i);
    return par(32'h1234_5678 + 32'h0101_0101 * 32'(i), 1'b0);
  endfunction
  task automatic chk36(input logic [35:0] g, input logic [35:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: flag %b want %b", $time, g, e);
    end
  endtask
  task automatic step(input logic [2:0] cs, input logic wn, input logic av, input logic [18:0] a,
                      input logic [3:0] bw, input logic [35:0] d);
    @(negedge clk_in);
    u_sbs_host_model.op(cs, wn, av, a, bw, d);
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) step(OFF, 1'b1, 1'b0, 19'h0, 4'hf, 36'h0);
  endtask
  task automatic rd(input logic [18:0] a);
    step(SEL, 1'b1, 1'b0, a, 4'hf, 36'h0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pipe_rw();
    m0 = (wd(1) & 36'hf_ffff_fe00) | (wd(2) & 36'h0_0000_01ff);
    step(SEL, 1'b0, 1'b0, 19'h10, 4'h0, wd(1));
    step(SEL, 1'b0, 1'b0, 19'h10, 4'he, wd(2));
    rd(19'h10);
    step(SEL, 1'b0, 1'b0, 19'h11, 4'h0, wd(0));
    chk1(oe_d, 1'b0);
    idle(1);
    chk1(oe_d, 1'b1);
    chk36(dq_d, m0);
    chk1(rd_err, 1'b0);
    rd(19'h11);
    idle(2);
    chk36(dq_d, wd(0));
    $display("test pipe_rw done");
  endtask
  task automatic t_flow();
    @(negedge clk_in);
    flow_sel_n = 1'b0;
    step(SEL, 1'b0, 1'b0, 19'h20, 4'h0, wd(3));
    rd(19'h20);
    chk1(oe_d, 1'b0);
    idle(1);
    chk1(oe_d, 1'b1);
    chk36(dq_d, wd(3));
    chk1(rd_err, 1'b0);
    idle(1);
    @(negedge clk_in);
    flow_sel_n = 1'b1;
    $display("test flow done");
  endtask
  task automatic t_burst();
    logic [1:0] o;
    for (int i = 0; i < 4; i++) step(SEL, 1'b0, 1'b0, 19'h30 + 19'(i), 4'h0, wd(4 + i));
    idle(2);
    for (int b = 0; b < 2; b++) begin
      @(negedge clk_in);
      order_sel_n = b[0];
      for (int k = 0; k < 6; k++) begin
        step(k < 4 ? SEL : OFF, 1'b1, k > 0 && k < 4, 19'h31, 4'hf, 36'h0);
        o = b[0] ? 2'(k + 2) ^ 2'h1 : 2'(k + 3);
        if (k > 1) chk36(dq_d, wd(4 + o));
      end
    end
    @(negedge clk_in);
    order_sel_n = 1'b0;
    $display("test burst done");
  endtask
  task automatic t_sel();
    step(SEL, 1'b0, 1'b0, 19'h40, 4'h0, wd(8));
    for (int c = 0; c < 8; c++) if (c != 2) step(3'(c), 1'b0, 1'b0, 19'h40, 4'h0, wd(9));
    idle(2);
    rd(19'h40);
    idle(2);
    chk36(dq_d, wd(8));
    $display("test select done");
  endtask
  task automatic t_hold();
    rd(19'h10);
    rd(19'h20);
    @(negedge clk_in);
    ce_n = 1'b1;
    repeat (3) @(negedge clk_in);
    chk36(dq_d, m0);
    oe_n = 1'b1;
    #1 chk1(oe_d, 1'b0);
    oe_n = 1'b0;
    slp = 1'b1;
    #1 chk1(oe_d, 1'b0);
    chk1(slp_d, 1'b1);
    slp = 1'b0;
    @(negedge clk_in);
    ce_n = 1'b0;
    idle(1);
    chk36(dq_d, wd(3));
    idle(1);
    $display("test hold done");
  endtask
  task automatic t_par();
    for (int p = 0; p < 2; p++) begin
      @(negedge clk_in);
      odd = p[0];
      step(SEL, 1'b0, 1'b0, 19'h50, 4'h0, par(32'h0000_00a5, ~p[0]));
      idle(2);
      chk1(wr_err, 1'b0);
      idle(1);
      chk1(wr_err, 1'b1);
      idle(1);
      chk1(wr_err, 1'b0);
      rd(19'h50);
      idle(2);
      chk1(rd_err, 1'b1);
    end
    @(negedge clk_in);
    odd = 1'b0;
    $display("test parity done");
  endtask
  task automatic tck_pulse(input logic m);
    @(negedge clk_in);
    tms = m;
    tck = 1'b1;
    repeat (2) @(negedge clk_in);
    tck = 1'b0;
    repeat (2) @(negedge clk_in);
    #1;
  endtask
  task automatic t_tap();
    tdi = 1'b1;
    tck_pulse(1'b0);
    tck_pulse(1'b1);
    tck_pulse(1'b0);
    tck_pulse(1'b0);
    chk1(tdo_oe, 1'b1);
    for (int i = 0; i < 32; i++) begin
      chk1(tdo, ID_CODE[i]);
      tck_pulse(1'b0);
    end
    chk1(tdo, tdi);
    tck_pulse(1'b1);
    chk1(tdo_oe, 1'b0);
    $display("test tap done");
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk_in);
    resetn_in = 1'b1;
    idle(1);
    t_pipe_rw();
    t_flow();
    t_burst();
    t_sel();
    t_hold();
    t_par();
    t_tap();
    give_verdict();
  end
endmodule
